/* src/quad_timer_event_capture.sv */
// Top of the quad timer with event counting, capture and Wishbone slave
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ns
module quad_timer_event_capture (
  input wire logic clock_i, // System clock, 50 MHz
  input wire logic rst_i, // Async reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [5:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic count_pin_a_i, // External count pin, timer 0
  input wire logic count_pin_b_i, // External count pin, timer 2
  input wire logic capture_trigger_a_i, // Capture trigger pin, pair A
  input wire logic capture_trigger_b_i, // Capture trigger pin, pair B
  output logic irq_o // Level interrupt
);
  logic [7:0] timer_pair_a_mode;
  logic [7:0] timer_pair_b_mode;
  logic [3:0] edge_select_reg;
  logic [qtmr_pkg::irq_bits-1:0] irq_status;
  logic [qtmr_pkg::irq_bits-1:0] irq_mask;
  logic [qtmr_pkg::irq_bits-1:0] irq_events;
  logic tick4;
  logic tick16;
  logic tick64;
  logic access;
  logic wr;
  logic [3:0] we_cmp;
  logic [7:0] rd_val [0:3];
  qtmr_pkg::pair_cfg_t cfg [0:1];
  qtmr_pkg::pair_evt_t evt [0:1];
  logic [31:0] next_rdata;

  qtmr_prescaler #(.width(6)) u_prescaler (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .tick4_o(tick4),
    .tick16_o(tick16),
    .tick64_o(tick64)
  );

  // Pair configuration from mode registers and the edge select register
  assign cfg[0] = '{capture: timer_pair_a_mode[qtmr_pkg::cap_bit],
                    odd_sel: timer_pair_a_mode[qtmr_pkg::odd_sel_hi:qtmr_pkg::odd_sel_lo],
                    even_sel: timer_pair_a_mode[qtmr_pkg::even_sel_hi:qtmr_pkg::even_sel_lo],
                    edge_sel: edge_select_reg[1:0]};
  assign cfg[1] = '{capture: timer_pair_b_mode[qtmr_pkg::cap_bit],
                    odd_sel: timer_pair_b_mode[qtmr_pkg::odd_sel_hi:qtmr_pkg::odd_sel_lo],
                    even_sel: timer_pair_b_mode[qtmr_pkg::even_sel_hi:qtmr_pkg::even_sel_lo],
                    edge_sel: edge_select_reg[3:2]};

  // Two identical pairs
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pair
      qtmr_pair u_pair (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .cfg_i(cfg[p]),
        .tick4_i(tick4),
        .tick16_i(tick16),
        .tick64_i(tick64),
        .count_pin_i(p == 0 ? count_pin_a_i : count_pin_b_i),
        .trig_pin_i(p == 0 ? capture_trigger_a_i : capture_trigger_b_i),
        .wdata_i(wb_dat_i[7:0]),
        .even_we_i(we_cmp[2*p]),
        .odd_we_i(we_cmp[2*p+1]),
        .even_rd_o(rd_val[2*p]),
        .odd_rd_o(rd_val[2*p+1]),
        .evt_o(evt[p])
      );
    end
  endgenerate

  // Bus decode: single-cycle ack, write in the cycle before ack
  assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = access & wb_we_i & wb_sel_i[0];
  assign we_cmp[0] = wr & (wb_adr_i == 6'(qtmr_pkg::off_timer0));
  assign we_cmp[1] = wr & (wb_adr_i == 6'(qtmr_pkg::off_timer1));
  assign we_cmp[2] = wr & (wb_adr_i == 6'(qtmr_pkg::off_timer2));
  assign we_cmp[3] = wr & (wb_adr_i == 6'(qtmr_pkg::off_timer3));

  // Ack generation
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) wb_ack_o <= 1'b0;
    else wb_ack_o <= access;
  end

  // Read mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      6'(qtmr_pkg::off_pair_a_mode): next_rdata[7:0] = timer_pair_a_mode;
      6'(qtmr_pkg::off_pair_b_mode): next_rdata[7:0] = timer_pair_b_mode;
      6'(qtmr_pkg::off_timer0): next_rdata[7:0] = rd_val[0];
      6'(qtmr_pkg::off_timer1): next_rdata[7:0] = rd_val[1];
      6'(qtmr_pkg::off_timer2): next_rdata[7:0] = rd_val[2];
      6'(qtmr_pkg::off_timer3): next_rdata[7:0] = rd_val[3];
      6'(qtmr_pkg::off_edge_sel): next_rdata[3:0] = edge_select_reg;
      6'(qtmr_pkg::off_irq_status): next_rdata[qtmr_pkg::irq_bits-1:0] = irq_status;
      qtmr_pkg::off_irq_mask_w: next_rdata[qtmr_pkg::irq_bits-1:0] = irq_mask;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data register
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) wb_dat_o <= 32'h0000_0000;
    else if (access && !wb_we_i) wb_dat_o <= next_rdata;
  end

  // Control registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      timer_pair_a_mode <= qtmr_pkg::mode_reset;
      timer_pair_b_mode <= qtmr_pkg::mode_reset;
      edge_select_reg <= 4'h0;
      irq_mask <= '0;
    end else if (wr) begin
      case (wb_adr_i)
        6'(qtmr_pkg::off_pair_a_mode): timer_pair_a_mode <= wb_dat_i[7:0];
        6'(qtmr_pkg::off_pair_b_mode): timer_pair_b_mode <= wb_dat_i[7:0];
        6'(qtmr_pkg::off_edge_sel): edge_select_reg <= wb_dat_i[3:0];
        qtmr_pkg::off_irq_mask_w: irq_mask <= wb_dat_i[qtmr_pkg::irq_bits-1:0];
        default: ;
      endcase
    end
  end

  // Event vector for the status register
  assign irq_events[qtmr_pkg::irq_match0] = evt[0].even_match;
  assign irq_events[qtmr_pkg::irq_match1] = evt[0].odd_match;
  assign irq_events[qtmr_pkg::irq_match2] = evt[1].even_match;
  assign irq_events[qtmr_pkg::irq_match3] = evt[1].odd_match;
  assign irq_events[qtmr_pkg::irq_ext_a] = evt[0].trig;
  assign irq_events[qtmr_pkg::irq_ext_b] = evt[1].trig;

  // Sticky status, write one to clear, set wins
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) irq_status <= '0;
    else if (wr && wb_adr_i == 6'(qtmr_pkg::off_irq_status))
      irq_status <= (irq_status & ~wb_dat_i[qtmr_pkg::irq_bits-1:0]) | irq_events;
    else irq_status <= irq_status | irq_events;
  end

  // Interrupt output
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) irq_o <= 1'b0;
    else irq_o <= |(irq_status & irq_mask);
  end
endmodule : quad_timer_event_capture

/* src/qtmr_pkg.sv */
// Package with register map, field layout and timing constants for the quad timer
package qtmr_pkg;
  // Word offsets (byte addresses) on the register bus
  localparam logic [4:0] off_pair_a_mode = 5'h00;
  localparam logic [4:0] off_pair_b_mode = 5'h04;
  localparam logic [4:0] off_timer0 = 5'h08;
  localparam logic [4:0] off_timer1 = 5'h0c;
  localparam logic [4:0] off_timer2 = 5'h10;
  localparam logic [4:0] off_timer3 = 5'h14;
  localparam logic [4:0] off_edge_sel = 5'h18;
  localparam logic [4:0] off_irq_status = 5'h1c;
  localparam logic [5:0] off_irq_mask_w = 6'h20;
  // Mode register field positions
  localparam int even_sel_lo = 0;
  localparam int even_sel_hi = 1;
  localparam int odd_sel_lo = 4;
  localparam int odd_sel_hi = 5;
  localparam int cap_bit = 7;
  // Clock select codes
  localparam logic [1:0] sel_ext = 2'h0;
  localparam logic [1:0] sel_div4 = 2'h1;
  localparam logic [1:0] sel_div16 = 2'h2;
  localparam logic [1:0] sel_div64 = 2'h3;
  // Prescaler ratios
  localparam int div_4 = 4;
  localparam int div_16 = 16;
  localparam int div_64 = 64;
  // Edge-select codes for the capture trigger
  localparam logic [1:0] edge_fall = 2'h1;
  localparam logic [1:0] edge_rise = 2'h2;
  localparam logic [1:0] edge_both = 2'h3;
  // Interrupt status bit positions
  localparam int irq_match0 = 0;
  localparam int irq_match1 = 1;
  localparam int irq_match2 = 2;
  localparam int irq_match3 = 3;
  localparam int irq_ext_a = 4;
  localparam int irq_ext_b = 5;
  localparam int irq_bits = 6;
  // Reset values
  localparam logic [7:0] mode_reset = 8'h00;
  localparam logic [7:0] compare_reset = 8'hff;
  // Configuration of one timer pair
  typedef struct packed {
    logic capture;
    logic [1:0] odd_sel;
    logic [1:0] even_sel;
    logic [1:0] edge_sel;
  } pair_cfg_t;
  // Events of one pair
  typedef struct packed {
    logic even_match;
    logic odd_match;
    logic trig;
  } pair_evt_t;
endpackage : qtmr_pkg

/* src/qtmr_prescaler.sv */
// Shared prescaler giving divide-by-4, 16 and 64 enable pulses
`timescale 1ns/1ns
module qtmr_prescaler #(
  parameter int width = 6
) (
  input wire logic clock_i, // System clock
  input wire logic rst_i, // Async reset, active high
  output logic tick4_o, // One-cycle pulse every 4 clocks
  output logic tick16_o, // One-cycle pulse every 16 clocks
  output logic tick64_o // One-cycle pulse every 64 clocks
);
  logic [width-1:0] count;

  initial begin
    if (width != 6) $error("prescaler width must be 6");
  end

  // Free-running divider
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) count <= '0;
    else count <= count + 1'b1;
  end

  // Pulses on terminal counts
  assign tick4_o = (count[1:0] == 2'(qtmr_pkg::div_4 - 1));
  assign tick16_o = (count[3:0] == 4'(qtmr_pkg::div_16 - 1));
  assign tick64_o = (count == 6'(qtmr_pkg::div_64 - 1));
endmodule : qtmr_prescaler

/* src/qtmr_pair.sv */
// One timer pair: two 8-bit counters or one cascaded 16-bit counter with capture
`timescale 1ns/1ns
module qtmr_pair (
  input wire logic clock_i, // System clock
  input wire logic rst_i, // Async reset, active high
  input wire qtmr_pkg::pair_cfg_t cfg_i, // Pair mode and clock selects
  input wire logic tick4_i, // Prescale pulse /4
  input wire logic tick16_i, // Prescale pulse /16
  input wire logic tick64_i, // Prescale pulse /64
  input wire logic count_pin_i, // External count pin, falling edge counts
  input wire logic trig_pin_i, // Capture trigger pin
  input wire logic [7:0] wdata_i, // Compare write data
  input wire logic even_we_i, // Write even compare
  input wire logic odd_we_i, // Write odd compare
  output logic [7:0] even_rd_o, // Even address read value
  output logic [7:0] odd_rd_o, // Odd address read value
  output qtmr_pkg::pair_evt_t evt_o // One-cycle events
);
  logic [7:0] even_cnt;
  logic [7:0] odd_cnt;
  logic [7:0] even_cmp;
  logic [7:0] odd_cmp;
  logic [15:0] capture;
  logic count_pin_q;
  logic trig_pin_q;
  logic ext_fall;
  logic trig_fall;
  logic trig_rise;
  logic trig;
  logic cascade;
  logic even_tick;
  logic odd_tick;
  logic even_hit;
  logic odd_hit;
  logic wide_hit;

  // Edge detection on the pins
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      count_pin_q <= 1'b1;
      trig_pin_q <= 1'b1;
    end else begin
      count_pin_q <= count_pin_i;
      trig_pin_q <= trig_pin_i;
    end
  end

  assign ext_fall = count_pin_q & ~count_pin_i;
  assign trig_fall = trig_pin_q & ~trig_pin_i;
  assign trig_rise = ~trig_pin_q & trig_pin_i;
  // Edge selection for capture trigger
  always_comb begin
    case (cfg_i.edge_sel)
      qtmr_pkg::edge_fall: trig = trig_fall;
      qtmr_pkg::edge_rise: trig = trig_rise;
      qtmr_pkg::edge_both: trig = trig_fall | trig_rise;
      default: trig = 1'b0;
    endcase
  end

  // Mode decode: zero odd select cascades
  assign cascade = (cfg_i.odd_sel == qtmr_pkg::sel_ext);

  // Even clock: external or prescaled
  always_comb begin
    case (cfg_i.even_sel)
      qtmr_pkg::sel_ext: even_tick = ext_fall;
      qtmr_pkg::sel_div4: even_tick = tick4_i;
      qtmr_pkg::sel_div16: even_tick = tick16_i;
      default: even_tick = tick64_i;
    endcase
  end

  // Odd clock: internal only
  always_comb begin
    case (cfg_i.odd_sel)
      qtmr_pkg::sel_div4: odd_tick = tick4_i;
      qtmr_pkg::sel_div16: odd_tick = tick16_i;
      qtmr_pkg::sel_div64: odd_tick = tick64_i;
      default: odd_tick = 1'b0;
    endcase
  end

  assign even_hit = even_tick & (even_cnt == even_cmp);
  assign odd_hit = odd_tick & (odd_cnt == odd_cmp);
  assign wide_hit = even_tick & ({odd_cnt, even_cnt} == {odd_cmp, even_cmp});

  // Compare registers, write only
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      even_cmp <= qtmr_pkg::compare_reset;
      odd_cmp <= qtmr_pkg::compare_reset;
    end else begin
      if (even_we_i) even_cmp <= wdata_i;
      if (odd_we_i) odd_cmp <= wdata_i;
    end
  end

  // Even counter (low byte when cascaded)
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) even_cnt <= 8'h00;
    else if (cfg_i.capture && trig) even_cnt <= 8'h00;
    else if (cascade && wide_hit) even_cnt <= 8'h00;
    else if (!cascade && even_hit) even_cnt <= 8'h00;
    else if (even_tick) even_cnt <= even_cnt + 8'h01;
  end

  // Odd counter (high byte when cascaded)
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) odd_cnt <= 8'h00;
    else if (cascade) begin
      if (cfg_i.capture && trig) odd_cnt <= 8'h00;
      else if (wide_hit) odd_cnt <= 8'h00;
      else if (even_tick && even_cnt == 8'hff) odd_cnt <= odd_cnt + 8'h01;
    end else if (odd_hit) odd_cnt <= 8'h00;
    else if (odd_tick) odd_cnt <= odd_cnt + 8'h01;
  end

  // Capture register
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) capture <= 16'h0000;
    else if (cfg_i.capture && trig) capture <= {cascade ? odd_cnt : 8'h00, even_cnt};
  end

  // Read paths and events
  assign even_rd_o = cfg_i.capture ? capture[7:0] : even_cnt;
  assign odd_rd_o = (cfg_i.capture && cascade) ? capture[15:8] : odd_cnt;
  assign evt_o.even_match = !cfg_i.capture && (cascade ? wide_hit : even_hit);
  assign evt_o.odd_match = !cascade && odd_hit;
  assign evt_o.trig = trig;
endmodule : qtmr_pair

/* bench/qtmr_pins.sv */
// Partner model driving the count pins and capture-trigger pins
`timescale 1ns/1ns
module qtmr_pins (
  input wire logic clock_i, // System clock
  output logic count_a_o, // Count pin, timer 0
  output logic count_b_o, // Count pin, timer 2
  output logic trig_a_o, // Trigger pin, pair A
  output logic trig_b_o // Trigger pin, pair B
);
  // Pins idle high, wired straight to the timers
  initial begin
    count_a_o = 1'b1;
    count_b_o = 1'b1;
    trig_a_o = 1'b1;
    trig_b_o = 1'b1;
  end
  // Falling edges, each level held two clocks
  task automatic count_edges(input bit b, input int n);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge clock_i);
      if (b) count_b_o <= i[0];
      else count_a_o <= i[0];
      @(posedge clock_i);
    end
  endtask : count_edges
  // Trigger level change
  task automatic set_trig(input bit b, input logic lvl);
    @(posedge clock_i);
    if (b) trig_b_o <= lvl;
    else trig_a_o <= lvl;
  endtask : set_trig
endmodule : qtmr_pins

/* bench/qtmr_sva.sv */
// Bus and interrupt assertions on the quad timer top ports
`timescale 1ns/1ns
module qtmr_sva (
  input wire logic clock_i, // System clock
  input wire logic rst_i, // Async reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [5:0] wb_adr_i, // Address
  input wire logic [3:0] wb_sel_i, // Byte selects
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Acknowledge
  input wire logic capture_trigger_a_i, // Trigger A
  input wire logic capture_trigger_b_i, // Trigger B
  input wire logic irq_o // Interrupt
);
  logic [5:0] mask_sh;
  logic [3:0] edge_sh;
  logic trig_a_q, trig_b_q, wr_take, hit;
  // Write taken at this edge
  assign wr_take = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  // Shadow of mask and edge select
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mask_sh <= 6'h00;
      edge_sh <= 4'h0;
    end else if (wr_take) begin
      if (wb_adr_i == qtmr_pkg::off_irq_mask_w) mask_sh <= wb_dat_i[5:0];
      if (wb_adr_i == {1'b0, qtmr_pkg::off_edge_sel}) edge_sh <= wb_dat_i[3:0];
    end
  end
  // Previous trigger levels
  always_ff @(posedge clock_i) begin
    trig_a_q <= capture_trigger_a_i;
    trig_b_q <= capture_trigger_b_i;
  end
  // Selected trigger edge on an unmasked pair
  assign hit = (mask_sh[4] & ((edge_sh[0] & trig_a_q & ~capture_trigger_a_i)
    | (edge_sh[1] & ~trig_a_q & capture_trigger_a_i)))
    | (mask_sh[5] & ((edge_sh[2] & trig_b_q & ~capture_trigger_b_i)
    | (edge_sh[3] & ~trig_b_q & capture_trigger_b_i)));
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_unmapped;
    wb_ack_o && !wb_we_i && wb_adr_i > 6'h23 |-> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_upper_zero;
    wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("read data above byte");
  property p_trig_irq;
    hit |-> ##[1:4] irq_o;
  endproperty
  a_trig_irq: assert property (p_trig_irq) else $error("trigger edge gave no irq");
  property p_mask_off;
    mask_sh == 6'h00 && $past(mask_sh) == 6'h00 |-> !irq_o;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq while all masked");
  property p_irq_cause;
    $rose(irq_o) |-> mask_sh != 6'h00 || $past(mask_sh) != 6'h00;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq rose with no mask");
endmodule : qtmr_sva
bind quad_timer_event_capture qtmr_sva sva_u (.clock_i(clock_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .capture_trigger_a_i(capture_trigger_a_i), .capture_trigger_b_i(capture_trigger_b_i),
  .irq_o(irq_o));

/* bench/testbench.sv */
// Self-checking bench for the quad timer with bus tasks and pin model
`timescale 1ns/1ns
module testbench;
  typedef struct {
    logic [31:0] exp;
    string what;
  } note_t;
  logic clock_i, rst_i, cyc, stb, we, ack, irq, pin_ca, pin_cb, pin_ta, pin_tb;
  logic [5:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r;
  note_t notes[$];
  int miscompares, total_checks, cycles, seed;
  // Clock
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  quad_timer_event_capture dut_u (.clock_i(clock_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .count_pin_a_i(pin_ca), .count_pin_b_i(pin_cb),
    .capture_trigger_a_i(pin_ta), .capture_trigger_b_i(pin_tb), .irq_o(irq));
  qtmr_pins pins_u (.clock_i(clock_i), .count_a_o(pin_ca), .count_b_o(pin_cb),
    .trig_a_o(pin_ta), .trig_b_o(pin_tb));
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Verdict and end of run
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  // Cycle ceiling against hangs
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end
  // Read data against the oldest note
  always @(posedge clock_i) begin
    if (ack === 1'b1 && we === 1'b0 && notes.size() > 0) begin
      note_t n;
      n = notes.pop_front();
      check(dat_r, n.exp, n.what);
    end
  end
  function automatic logic [5:0] ad(input logic [4:0] o);
    return {1'b0, o};
  endfunction : ad
  // Classic single bus cycle, held until ack
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clock_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= 4'h1 | 4'($random(seed));
    do @(posedge clock_i); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input string what);
    notes.push_back('{e, what});
    bus(1'b0, a, 32'h0);
  endtask : rd
  task do_reset;
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
  endtask : do_reset
  // Main sequence
  initial begin
    int c, d, dv;
    time t0;
    seed = 32'h3665;
    rst_i = 1'b1;
    {cyc, stb, we} = 3'b000;
    adr = 6'h00;
    sel = 4'h1;
    dat_w = 32'h0;
    do_reset();
    rd(ad(qtmr_pkg::off_pair_a_mode), 32'h0, "mode reset");
    rd(ad(qtmr_pkg::off_irq_status), 32'h0, "status reset");
    rd(6'h24, 32'h0, "unmapped");
    // Odd timer match period for each prescale code
    for (d = 1; d < 4; d++) begin
      do_reset();
      c = 2 + ($random(seed) & 3);
      dv = (d == 1) ? qtmr_pkg::div_4 : (d == 2) ? qtmr_pkg::div_16 : qtmr_pkg::div_64;
      wr(ad(qtmr_pkg::off_timer1), c);
      wr(ad(qtmr_pkg::off_pair_a_mode), (d << 4) | d);
      wr(qtmr_pkg::off_irq_mask_w, 32'h2);
      while (irq !== 1'b1) @(posedge clock_i);
      t0 = $time;
      wr(ad(qtmr_pkg::off_irq_status), 32'h3f);
      while (irq !== 1'b0) @(posedge clock_i);
      while (irq !== 1'b1) @(posedge clock_i);
      check(32'(($time - t0) / 20), 32'((c + 1) * dv), "period");
    end
    // Event counting, pair A 8-bit and pair B 16-bit together
    do_reset();
    wr(ad(qtmr_pkg::off_timer0), 32'h7);
    wr(ad(qtmr_pkg::off_timer2), 32'h1);
    wr(ad(qtmr_pkg::off_timer3), 32'h1);
    wr(ad(qtmr_pkg::off_pair_a_mode), 32'h30);
    fork
      pins_u.count_edges(1'b0, 5);
      pins_u.count_edges(1'b1, 256);
    join
    rd(ad(qtmr_pkg::off_timer0), 32'h5, "event count");
    rd(ad(qtmr_pkg::off_timer2), 32'h0, "low byte");
    rd(ad(qtmr_pkg::off_timer3), 32'h1, "high byte");
    fork
      pins_u.count_edges(1'b0, 3);
      pins_u.count_edges(1'b1, 2);
    join
    rd(ad(qtmr_pkg::off_timer0), 32'h0, "cleared");
    rd(ad(qtmr_pkg::off_timer3), 32'h0, "cleared wide");
    rd(ad(qtmr_pkg::off_irq_status), 32'h5, "flags");
    // Capture on each edge code, pair A 8-bit and pair B 16-bit
    do_reset();
    wr(ad(qtmr_pkg::off_timer0), 32'h1);
    wr(ad(qtmr_pkg::off_pair_a_mode), 32'hb0);
    wr(ad(qtmr_pkg::off_pair_b_mode), 32'h80);
    wr(qtmr_pkg::off_irq_mask_w, 32'h30);
    for (d = 1; d < 4; d++) begin
      wr(ad(qtmr_pkg::off_edge_sel), 32'(d * 5));
      fork
        pins_u.count_edges(1'b0, 3);
        pins_u.count_edges(1'b1, (d == 1) ? 258 : 2);
      join
      fork
        pins_u.set_trig(1'b0, 1'b0);
        pins_u.set_trig(1'b1, 1'b0);
      join
      repeat (4) @(posedge clock_i);
      check(irq, 32'(d[0]), "fall irq");
      rd(ad(qtmr_pkg::off_irq_status), d[0] ? 32'h30 : 32'h0, "fall flag");
      wr(ad(qtmr_pkg::off_irq_status), 32'h3f);
      fork
        pins_u.set_trig(1'b0, 1'b1);
        pins_u.set_trig(1'b1, 1'b1);
      join
      repeat (4) @(posedge clock_i);
      rd(ad(qtmr_pkg::off_irq_status), d[1] ? 32'h30 : 32'h0, "rise flag");
      wr(ad(qtmr_pkg::off_irq_status), 32'h3f);
      rd(ad(qtmr_pkg::off_timer0), (d == 3) ? 32'h0 : 32'h1, "captured");
      rd(ad(qtmr_pkg::off_timer2), (d == 3) ? 32'h0 : 32'h2, "captured low");
      rd(ad(qtmr_pkg::off_timer3), (d == 1) ? 32'h1 : 32'h0, "captured high");
    end
    // Masking a pending flag drops the interrupt
    pins_u.set_trig(1'b0, 1'b0);
    repeat (4) @(posedge clock_i);
    check(irq, 32'h1, "irq set");
    wr(qtmr_pkg::off_irq_mask_w, 32'h0);
    repeat (3) @(posedge clock_i);
    check(irq, 32'h0, "irq masked");
    test_done();
  end
endmodule : testbench
